/* verilog/tpg_gate_ctrl.v */
// top of the three-phase gate drive control: serial setup port, phase
// flags and the gate command path for three phases
// assumes pins arrive unsynchronised; switch-node and supply levels are
// digitised samples on clk_in
//
// What this block does
// - gates on only when both enables high
// - upper command input is active low
// - lower command input is active high
// - phase flag low below half supply
// - chip select low frames one command
// - serial input sampled on falling clock, MSB first
// - serial output tri-state while chip select high
// - reset, enables asynchronous; dedicated interrupt output
// - programmable dead time between phase switches
// - overlap only after protected serial unlock
// - disabled: gates off, logic keeps running
// - no simultaneous upper and lower by default
`timescale 1ns/1ps
`include "tpg_regs.vh"

module tpg_gate_ctrl (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       dev_reset_n_in,
    input  wire       drive_enable_a_in,
    input  wire       drive_enable_b_in,
    input  wire       phase_a_upper_cmd_n_in,
    input  wire       phase_a_lower_cmd_in,
    input  wire       phase_b_upper_cmd_n_in,
    input  wire       phase_b_lower_cmd_in,
    input  wire       phase_c_upper_cmd_n_in,
    input  wire       phase_c_lower_cmd_in,
    input  wire [7:0] phase_a_switch_node_in,
    input  wire [7:0] phase_b_switch_node_in,
    input  wire [7:0] phase_c_switch_node_in,
    input  wire [7:0] load_supply_level_in,
    input  wire       spi_cs_n_in,
    input  wire       spi_sclk_in,
    input  wire       spi_si_in,
    output wire       spi_so_out,
    output wire       spi_so_oe_out,
    output wire       irq_out,
    output wire [2:0] upper_gate_out,
    output wire [2:0] lower_gate_out,
    output wire       phase_a_level_flag_out,
    output wire       phase_b_level_flag_out,
    output wire       phase_c_level_flag_out
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // order: cs_n, sclk, si, en_a, en_b, rst_n, 3 upper_n, 3 lower
    wire [11:0] pin_w;
    reg  [11:0] sync1_q;
    reg  [11:0] sync2_q;

    assign pin_w = {phase_c_lower_cmd_in, phase_b_lower_cmd_in, phase_a_lower_cmd_in,
                    phase_c_upper_cmd_n_in, phase_b_upper_cmd_n_in, phase_a_upper_cmd_n_in,
                    dev_reset_n_in, drive_enable_b_in, drive_enable_a_in,
                    spi_si_in, spi_sclk_in, spi_cs_n_in};

    // reset to the idle pin levels, upper commands high, so that no phase
    // looks requested while the synchronisers refill after reset
    always @(posedge clk_in) begin
        if (rst_in) begin
            sync1_q <= 12'h1F9;
            sync2_q <= 12'h1F9;
        end else begin
            sync1_q <= pin_w;
            sync2_q <= sync1_q;
        end
    end

    wire       cs_n_s   = sync2_q[0];
    wire       sclk_s   = sync2_q[1];
    wire       si_s     = sync2_q[2];
    wire       enable_s = sync2_q[3] & sync2_q[4];
    wire       dreset_s = ~sync2_q[5];
    wire [2:0] req_up_w = ~sync2_q[8:6];
    wire [2:0] req_lo_w = sync2_q[11:9];

    // ****************************************************************
    // serial edge detection
    // ****************************************************************
    reg  sclk_prev_q;
    reg  cs_prev_q;
    wire sclk_fall_w;
    wire sclk_rise_w;
    wire cs_fall_w;
    wire cs_rise_w;

    always @(posedge clk_in) begin
        if (rst_in) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_prev_q   <= cs_n_s;
        end
    end

    assign sclk_fall_w = sclk_prev_q & ~sclk_s & ~cs_n_s;
    assign sclk_rise_w = ~sclk_prev_q & sclk_s & ~cs_n_s;
    assign cs_fall_w   = cs_prev_q & ~cs_n_s;
    assign cs_rise_w   = ~cs_prev_q & cs_n_s;

    // ****************************************************************
    // serial shift path
    // ****************************************************************
    reg  [7:0] rx_q;
    reg  [7:0] tx_q;
    reg  [3:0] bits_q;
    reg        so_q;
    reg  [4:0] dead_time_q;
    reg        overlap_en_q;
    reg        armed_q;
    reg        err_q;
    wire [7:0] status_w;
    wire       good_w;
    wire [2:0] op_w;

    assign status_w = {overlap_en_q, armed_q, err_q, dead_time_q};
    assign good_w   = (bits_q == `TPG_FRAME_BITS);
    assign op_w     = rx_q[`TPG_OP_MSB:`TPG_OP_LSB];

    always @(posedge clk_in) begin
        if (rst_in) begin
            rx_q   <= 8'h00;
            tx_q   <= 8'h00;
            bits_q <= 4'h0;
            so_q   <= 1'b0;
        end else if (cs_fall_w) begin
            tx_q   <= status_w;
            bits_q <= 4'h0;
        end else begin
            if (sclk_fall_w) begin
                rx_q <= {rx_q[6:0], si_s};
                if (bits_q != 4'hF) begin
                    bits_q <= bits_q + 4'h1;
                end
            end
            if (sclk_rise_w) begin
                so_q <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // ****************************************************************
    // command execution at end of frame
    // ****************************************************************
    // a frame with the wrong bit count is dropped whole and flagged
    always @(posedge clk_in) begin
        if (rst_in || dreset_s) begin
            dead_time_q  <= `TPG_DT_RESET;
            overlap_en_q <= `TPG_OVL_RESET;
            armed_q      <= 1'b0;
            err_q        <= 1'b0;
        end else if (cs_rise_w) begin
            armed_q <= 1'b0;
            if (!good_w) begin
                err_q <= 1'b1;
            end else if (rx_q == `TPG_UNLOCK_KEY) begin
                armed_q <= 1'b1;
            end else if (op_w == `TPG_OP_DEADTIME) begin
                dead_time_q <= rx_q[`TPG_ARG_MSB:`TPG_ARG_LSB];
            end else if (op_w == `TPG_OP_OVERLAP) begin
                if (armed_q) begin
                    overlap_en_q <= rx_q[0];
                end else begin
                    err_q <= 1'b1;
                end
            end else if (op_w == `TPG_OP_STATUS) begin
                err_q <= 1'b0;
            end else begin
                err_q <= 1'b1;
            end
        end
    end

    assign spi_so_out    = so_q;
    assign spi_so_oe_out = ~cs_n_s & ~cs_prev_q;
    assign irq_out       = err_q;

    // ****************************************************************
    // phase comparator flags
    // ****************************************************************
    reg [2:0] flag_q;

    always @(posedge clk_in) begin
        if (rst_in) begin
            flag_q <= 3'h0;
        end else begin
            flag_q[0] <= ({phase_a_switch_node_in, 1'b0} >= {1'b0, load_supply_level_in});
            flag_q[1] <= ({phase_b_switch_node_in, 1'b0} >= {1'b0, load_supply_level_in});
            flag_q[2] <= ({phase_c_switch_node_in, 1'b0} >= {1'b0, load_supply_level_in});
        end
    end

    assign phase_a_level_flag_out = flag_q[0];
    assign phase_b_level_flag_out = flag_q[1];
    assign phase_c_level_flag_out = flag_q[2];

    // ****************************************************************
    // gate path
    // ****************************************************************
    // the pin-level gate below bypasses the synchronisers so that a drop
    // of enable or reset kills the drive without waiting on clk_in
    wire [2:0] up_on_w;
    wire [2:0] lo_on_w;
    wire       drive_ok_w;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_phase
            tpg_phase_dt u_dt (
                .clk_in        (clk_in),
                .rst_in        (rst_in),
                .force_off_in  (~enable_s | dreset_s),
                .req_upper_in  (req_up_w[gi]),
                .req_lower_in  (req_lo_w[gi]),
                .dead_time_in  (dead_time_q),
                .overlap_en_in (overlap_en_q),
                .upper_on_out  (up_on_w[gi]),
                .lower_on_out  (lo_on_w[gi])
            );
        end
    endgenerate

    assign drive_ok_w     = drive_enable_a_in & drive_enable_b_in & dev_reset_n_in;
    assign upper_gate_out = up_on_w & {3{drive_ok_w}};
    assign lower_gate_out = lo_on_w & {3{drive_ok_w}};

endmodule

/* verilog/tpg_regs.vh */
// constants of the three-phase gate drive control block
// assumes a 10 MHz system clock and a serial link far slower than it
`ifndef TPG_REGS_VH
`define TPG_REGS_VH

// ****************************************************************
// timing
// ****************************************************************
`define TPG_CLK_NS          100
`define TPG_DT_STEP_NS      100
`define TPG_DT_STEP_CYC     ((`TPG_DT_STEP_NS + `TPG_CLK_NS - 1) / `TPG_CLK_NS)

// ****************************************************************
// serial frame layout
// ****************************************************************
`define TPG_FRAME_BITS      4'h8
`define TPG_OP_MSB          7
`define TPG_OP_LSB          5
`define TPG_ARG_MSB         4
`define TPG_ARG_LSB         0

// ****************************************************************
// commands
// ****************************************************************
`define TPG_OP_DEADTIME     3'h4
`define TPG_OP_OVERLAP      3'h6
`define TPG_OP_STATUS       3'h0
`define TPG_UNLOCK_KEY      8'hA5

// ****************************************************************
// reset values
// ****************************************************************
`define TPG_DT_RESET        5'h04
`define TPG_OVL_RESET       1'b0

`endif

/* verilog/tpg_phase_dt.v */
// one phase of dead-time and cross-conduction logic
// assumes requests are already synchronised and active high
`timescale 1ns/1ps
`include "tpg_regs.vh"

module tpg_phase_dt (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       force_off_in,
    input  wire       req_upper_in,
    input  wire       req_lower_in,
    input  wire [4:0] dead_time_in,
    input  wire       overlap_en_in,
    output wire       upper_on_out,
    output wire       lower_on_out
);

    reg         upper_q;
    reg         lower_q;
    reg  [7:0]  cnt_q;
    reg         upper_d;
    reg         lower_d;
    reg  [7:0]  cnt_d;
    wire        both_w;
    wire [31:0] load_w;

    // ****************************************************************
    // next state
    // ****************************************************************
    // both requested without override: neither side turns on
    assign both_w = req_upper_in & req_lower_in & ~overlap_en_in;
    assign load_w = dead_time_in * `TPG_DT_STEP_CYC;

    always @* begin
        upper_d = 1'b0;
        lower_d = 1'b0;
        cnt_d   = cnt_q;
        if (!force_off_in && !both_w) begin
            if (overlap_en_in) begin
                upper_d = req_upper_in;
                lower_d = req_lower_in;
            end else begin
                // the other side must be off and the gap run out first
                upper_d = req_upper_in & ~lower_q & (upper_q | (cnt_q == 8'h00));
                lower_d = req_lower_in & ~upper_q & (lower_q | (cnt_q == 8'h00));
            end
        end
        if ((upper_q & ~upper_d) | (lower_q & ~lower_d)) begin
            cnt_d = load_w[7:0];
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    // ****************************************************************
    // state
    // ****************************************************************
    always @(posedge clk_in) begin
        if (rst_in) begin
            upper_q <= 1'b0;
            lower_q <= 1'b0;
            cnt_q   <= 8'h00;
        end else begin
            upper_q <= upper_d;
            lower_q <= lower_d;
            cnt_q   <= cnt_d;
        end
    end

    assign upper_on_out = upper_q;
    assign lower_on_out = lower_q;

endmodule

/* sim/tpg_gate_ctrl_sva.sv */
// checker of the gate drive control top, ports only
// assumes the bench never enables overlap and keeps dead time >= 4 steps
`timescale 1ns/1ps
module tpg_gate_ctrl_chk (
    input wire       clk_in,
    input wire       rst_in,
    input wire       dev_reset_n_in,
    input wire       drive_enable_a_in,
    input wire       drive_enable_b_in,
    input wire [7:0] phase_a_switch_node_in,
    input wire [7:0] load_supply_level_in,
    input wire       spi_cs_n_in,
    input wire       spi_sclk_in,
    input wire       spi_so_out,
    input wire       spi_so_oe_out,
    input wire       irq_out,
    input wire [2:0] upper_gate_out,
    input wire [2:0] lower_gate_out,
    input wire       phase_a_level_flag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire [8:0] node_x2 = {phase_a_switch_node_in, 1'b0};
    gates_enable_a:
        assert property (!(drive_enable_a_in && drive_enable_b_in)
            |-> (upper_gate_out | lower_gate_out) == 3'h0) else $error("gate on while disabled");
    pin_reset_a:
        assert property (!dev_reset_n_in |-> (upper_gate_out | lower_gate_out) == 3'h0)
            else $error("gate on during device reset");
    reset_quiet_a:
        assert property ($fell(rst_in) |-> ((upper_gate_out | lower_gate_out) == 3'h0) [*3])
            else $error("gate on after reset");
    no_shoot_a:
        assert property ((upper_gate_out & lower_gate_out) == 3'h0) else $error("both sides on");
    dead_gap_a:
        assert property ($rose(upper_gate_out[0]) |-> $past(lower_gate_out[0], 5) == 1'b0)
            else $error("upper on too soon");
    so_idle_a:
        assert property (spi_cs_n_in [*3] |-> !spi_so_oe_out) else $error("so driven idle");
    so_drive_a:
        assert property ($fell(spi_cs_n_in) ##1 !spi_cs_n_in [*2] |-> ##[0:2] spi_so_oe_out)
            else $error("so not driven in frame");
    so_steady_a:
        assert property (!spi_sclk_in [*5] |-> $stable(spi_so_out)) else $error("so moved");
    irq_frame_a:
        assert property ($rose(irq_out) |-> $past(spi_cs_n_in, 1) && $past(spi_cs_n_in, 2))
            else $error("irq outside frame end");
    flag_half_a:
        assert property (phase_a_level_flag_out
            == ($past(node_x2) >= {1'b0, $past(load_supply_level_in)})) else $error("flag wrong");
    cover property ($rose(upper_gate_out[0]));
    cover property ($rose(irq_out));
    cover property ($rose(spi_so_oe_out));
endmodule

bind tpg_gate_ctrl tpg_gate_ctrl_chk i_tpg_gate_ctrl_chk (.clk_in, .rst_in, .dev_reset_n_in,
    .drive_enable_a_in, .drive_enable_b_in, .phase_a_switch_node_in, .load_supply_level_in,
    .spi_cs_n_in, .spi_sclk_in, .spi_so_out, .spi_so_oe_out, .irq_out, .upper_gate_out,
    .lower_gate_out, .phase_a_level_flag_out);

/* sim/tpg_host_model.sv */
// host side of the serial link: master sending one byte per call
// assumes the device shifts out on rising clock and samples on falling
`timescale 1ns/1ps
module tpg_host_model (
    output reg  spi_cs_n_out,
    output reg  spi_sclk_out,
    output reg  spi_si_out,
    input  wire spi_so_in,
    input  wire spi_so_oe_in
);
    wire so_line = spi_so_oe_in ? spi_so_in : 1'bz;
    initial begin
        spi_cs_n_out = 1'b1;
        spi_sclk_out = 1'b0;
        spi_si_out = 1'b0;
    end
    // 800 ns period, slower than typical: edge detect needs 3 clocks a phase
    task frame(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            #37 spi_cs_n_out = 1'b0;
            for (i = 7; i >= 0; i = i - 1) begin
                #200 spi_si_out = tx[i];
                #150 spi_sclk_out = 1'b1;
                #450 rx[i] = so_line;
                spi_sclk_out = 1'b0;
            end
            #400 spi_cs_n_out = 1'b1;
            spi_si_out = ~spi_si_out;
            #1000;
        end
    endtask
endmodule

/* sim/test_tpg_gate_ctrl.sv */
// self-checking bench of the gate drive control top
// assumes the host model and the bound checker are compiled beside it
`timescale 1ns/1ps
`include "tpg_regs.vh"
module test_tpg_gate_ctrl;
    reg        clk_in, rst_in, dev_reset_n_in, en_a, en_b;
    reg  [2:0] up_n, lo;
    reg  [7:0] node_a, node_b, node_c, supply, rx;
    wire       cs_n, sclk, si, so, so_oe, irq, flag_a, flag_b, flag_c;
    wire [2:0] upper_gate, lower_gate;
    integer    mismatches, n_compared;

    tpg_gate_ctrl i_tpg_gate_ctrl (.clk_in(clk_in), .rst_in(rst_in),
        .dev_reset_n_in(dev_reset_n_in), .drive_enable_a_in(en_a), .drive_enable_b_in(en_b),
        .phase_a_upper_cmd_n_in(up_n[0]), .phase_a_lower_cmd_in(lo[0]),
        .phase_b_upper_cmd_n_in(up_n[1]), .phase_b_lower_cmd_in(lo[1]),
        .phase_c_upper_cmd_n_in(up_n[2]), .phase_c_lower_cmd_in(lo[2]),
        .phase_a_switch_node_in(node_a), .phase_b_switch_node_in(node_b),
        .phase_c_switch_node_in(node_c), .load_supply_level_in(supply),
        .spi_cs_n_in(cs_n), .spi_sclk_in(sclk), .spi_si_in(si), .spi_so_out(so),
        .spi_so_oe_out(so_oe), .irq_out(irq), .upper_gate_out(upper_gate),
        .lower_gate_out(lower_gate), .phase_a_level_flag_out(flag_a),
        .phase_b_level_flag_out(flag_b), .phase_c_level_flag_out(flag_c));
    tpg_host_model i_tpg_host_model (.spi_cs_n_out(cs_n), .spi_sclk_out(sclk),
        .spi_si_out(si), .spi_so_in(so), .spi_so_oe_in(so_oe));

    task check(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_in);
    endtask
    task conclude;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_gates;
        begin
            @(posedge clk_in); up_n <= 3'b101; lo <= 3'b101;
            tick(12);
            check({2'h0, upper_gate, lower_gate}, 8'h15);
            @(posedge clk_in); en_a <= 1'b0;
            #1 check({5'h0, upper_gate | lower_gate}, 8'h00);
            @(posedge clk_in); en_a <= 1'b1;
            tick(12);
            check({2'h0, upper_gate, lower_gate}, 8'h15);
            @(posedge clk_in); dev_reset_n_in <= 1'b0;
            #1 check({5'h0, upper_gate | lower_gate}, 8'h00);
            tick(4);
            dev_reset_n_in <= 1'b1;
            up_n[0] <= 1'b0; // phase a now asks for both sides
            tick(12);
            check({7'h0, upper_gate[0] | lower_gate[0]}, 8'h00);
            $display("done gates");
        end
    endtask
    // counts cycles with both sides of phase a off across a lower to upper swap
    task t_dead(input [7:0] exp);
        integer i, n;
        begin
            @(posedge clk_in); up_n[0] <= 1'b1; lo[0] <= 1'b1;
            tick(40);
            @(posedge clk_in); up_n[0] <= 1'b0; lo[0] <= 1'b0;
            n = 0;
            for (i = 0; i < 60; i = i + 1) begin
                @(negedge clk_in);
                if (upper_gate[0] === 1'b0 && lower_gate[0] === 1'b0) n = n + 1;
            end
            check(n[7:0], exp);
            check({7'h0, upper_gate[0]}, 8'h01);
            $display("done dead time");
        end
    endtask
    task t_spi;
        begin
            @(posedge clk_in); en_b <= 1'b0;
            #1 check({7'h0, so_oe}, 8'h00);
            i_tpg_host_model.frame(8'h00, rx);
            check(rx, 8'h04);
            @(posedge clk_in); en_b <= 1'b1;
            i_tpg_host_model.frame(8'h86, rx); // dead time 6 steps
            check(rx, 8'h04);
            i_tpg_host_model.frame(8'hC1, rx); // overlap without unlock
            check(rx, 8'h06);
            tick(5);
            check({7'h0, irq}, 8'h01);
            check({7'h0, so_oe}, 8'h00);
            i_tpg_host_model.frame(8'h00, rx);
            check(rx, 8'h26);
            tick(5);
            check({7'h0, irq}, 8'h00);
            i_tpg_host_model.frame(8'hA5, rx); // unlock
            check(rx, 8'h06);
            i_tpg_host_model.frame(8'hC0, rx); // protected overlap write, kept off
            check(rx, 8'h46);
            tick(5);
            check({7'h0, irq}, 8'h00);
            i_tpg_host_model.frame(8'h20, rx); // unknown command
            check(rx, 8'h06);
            tick(5);
            check({7'h0, irq}, 8'h01);
            i_tpg_host_model.frame(8'h00, rx);
            check(rx, 8'h26);
            tick(5);
            check({7'h0, irq}, 8'h00);
            $display("done serial");
            t_dead(8'(6 * `TPG_DT_STEP_CYC + 1));
        end
    endtask
    task t_flags;
        begin
            @(posedge clk_in); node_a <= 8'h40; node_b <= 8'h3F; node_c <= 8'hFF;
            tick(4);
            check({5'h0, flag_a, flag_b, flag_c}, 8'h05);
            $display("done flags");
        end
    endtask

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        #1000000 mismatches = mismatches + 1;
        conclude;
    end
    initial begin
        rst_in = 1'b1; dev_reset_n_in = 1'b1; en_a = 1'b1; en_b = 1'b1;
        up_n = 3'h7; lo = 3'h0; node_a = 8'h00; node_b = 8'h00; node_c = 8'h00;
        supply = 8'h80; rx = 8'h00; mismatches = 0; n_compared = 0;
        tick(20);
        rst_in <= 1'b0;
        tick(3);
        t_gates;
        t_dead(8'(`TPG_DT_RESET * `TPG_DT_STEP_CYC + 1));
        t_spi;
        t_flags;
        conclude;
    end
endmodule
